// ==== inc/mrp_pkg.sv ====
// Constants for the register-to-point mapper
package mrp_pkg;
   // ==========================================
   // Function codes
   localparam logic [7:0] FC_RD_COILS = 8'h01;
   localparam logic [7:0] FC_RD_DISC = 8'h02;
   localparam logic [7:0] FC_RD_HOLD = 8'h03;
   localparam logic [7:0] FC_RD_INPUT = 8'h04;
   localparam logic [7:0] FC_WR_ONE = 8'h06;
   localparam logic [7:0] FC_WR_MULTI = 8'h10;
   // ==========================================
   // Exception codes
   localparam logic [7:0] EXC_NONE = 8'h00;
   localparam logic [7:0] EXC_ILL_FUNC = 8'h01;
   localparam logic [7:0] EXC_ILL_ADDR = 8'h02;
   localparam logic [7:0] EXC_ILL_VALUE = 8'h03;
   localparam logic [7:0] EXC_RSP_LEN = 8'h04;
   localparam logic [7:0] EXC_GW_NO_RSP = 8'h0a;
   // ==========================================
   // Response sizing
   localparam logic [17:0] MAX_RSP_BYTES = 18'h00100;
   localparam logic [17:0] RSP_HDR_BYTES = 18'h00002;
   localparam logic [16:0] POINT_LIMIT = 17'h10000;
   localparam logic [15:0] ONE_REG = 16'h0001;
   localparam logic [15:0] TWO_REG = 16'h0002;
   localparam logic [2:0] BIT_LAST = 3'h7;
   // ==========================================
   // Configured point object types
   typedef enum logic [2:0] {
      PT_BINARY = 3'h0,
      PT_AI16 = 3'h1,
      PT_CTR16 = 3'h2,
      PT_AI32 = 3'h3,
      PT_CTR32 = 3'h4,
      PT_FLOAT = 3'h5
   } mrp_ptype_t;
endpackage

// ==== rtl/mrp_point_mapper.sv ====
// Register request walker mapping register addresses onto database points
`timescale 1ns/1ps
// Functional notes
// - Multi-write starts at the point of the start address; count and widths decide reach.
// - Unmapped reference number r addresses point r plus one.
// - 16-bit point takes one register, 32-bit takes two; overrunning point is skipped.
// - 16-bit point write takes the single register value.
// - A table of entries gives start point and count of 32-bit pair points.
// - Mapped points use fixed pair assignment regardless of request start or count.
// - Entry at 1001: pair at 41005 resolves to point 1003.
// - Single write to the high word of a mapped pair gets an exception.
// - Multi-register request starting on a mapped high word gets an exception.
// - Returned data type follows each point's configured object type.
// - 32-bit signed: low bits in first register, high bits in second.
// - Float: low half first register, high half with exponent second.
// - 32-bit counter: unsigned, low word first, high word second.
// - 16-bit analog is signed, 16-bit counter unsigned, one register each.
// - Binary values packed into bytes, lowest discrete in least significant bit.
// - Codes 0x01 bad function, 0x02 bad register, 0x03 bad value.
// - Code 0x04 when the response would exceed 256 bytes.
// - Gateway mode returns 0x0a when the remote target does not answer.
// - Multi-write stops at first invalid point or failed control, code 01.
// - Multi-read succeeds with zeros if any point valid, else code 01.
module mrp_point_mapper #(
   parameter int NMAP = 4,
   parameter int AW = 8
) (
   input wire logic clk_sys_i,
   input wire logic rst_n_i,
   input wire logic [NMAP*16-1:0] map_start_i,
   input wire logic [NMAP*16-1:0] map_qty_i,
   input wire logic req_valid_i,
   output logic req_ready_o,
   input wire logic [7:0] req_func_i,
   input wire logic [15:0] req_start_i,
   input wire logic [15:0] req_count_i,
   input wire logic gw_mode_i,
   input wire logic gw_reply_i,
   input wire logic gw_timeout_i,
   output logic [AW-1:0] req_word_idx_o,
   input wire logic [15:0] req_word_i,
   input wire logic [15:0] req_word_next_i,
   output logic [15:0] pt_num_o,
   input wire logic pt_exists_i,
   input wire logic [2:0] pt_type_i,
   input wire logic [31:0] pt_rdata_i,
   output logic pt_wr_o,
   output logic [31:0] pt_wdata_o,
   input wire logic pt_wr_ok_i,
   output logic rsp_valid_o,
   output logic [15:0] rsp_data_o,
   output logic rsp_done_o,
   output logic [7:0] rsp_exc_o
);
   // ==========================================
   // State
   typedef enum logic [2:0] {ST_IDLE, ST_WALK, ST_HIGH, ST_GW, ST_DONE} mrp_state_t;
   mrp_state_t st;
   logic [7:0] func;
   logic [16:0] cur_ref;
   logic [15:0] remain;
   logic [AW-1:0] widx;
   logic any_ok;
   logic first;
   logic [7:0] exc;
   logic [15:0] hi_word;
   logic [7:0] bit_sh;
   logic [2:0] bit_cnt;
   logic [15:0] out_word;
   logic out_valid;

   // ==========================================
   // Request classification at acceptance
   wire accept = req_valid_i && st == ST_IDLE;
   wire in_bin = req_func_i == mrp_pkg::FC_RD_COILS || req_func_i == mrp_pkg::FC_RD_DISC;
   wire in_reg = req_func_i == mrp_pkg::FC_RD_HOLD || req_func_i == mrp_pkg::FC_RD_INPUT
      || req_func_i == mrp_pkg::FC_WR_MULTI;
   wire in_one = req_func_i == mrp_pkg::FC_WR_ONE;
   wire in_rd_reg = req_func_i == mrp_pkg::FC_RD_HOLD || req_func_i == mrp_pkg::FC_RD_INPUT;
   wire [15:0] in_count = in_one ? mrp_pkg::ONE_REG : req_count_i;
   wire [17:0] rd_bytes = in_bin ? (mrp_pkg::RSP_HDR_BYTES + {5'h00, in_count[15:3]}
      + {17'h00000, |in_count[2:0]}) : (mrp_pkg::RSP_HDR_BYTES + {1'b0, in_count, 1'b0});
   wire too_long = (in_bin || in_rd_reg) && rd_bytes > mrp_pkg::MAX_RSP_BYTES;
   wire [7:0] pre_exc = !(in_bin || in_reg || in_one) ? mrp_pkg::EXC_ILL_FUNC :
      in_count == 16'h0000 ? mrp_pkg::EXC_ILL_VALUE :
      too_long ? mrp_pkg::EXC_RSP_LEN : mrp_pkg::EXC_NONE;

   // ==========================================
   // Pair mapping table lookup
   logic [NMAP-1:0] hit;
   logic [16:0] ent_pt [NMAP];
   logic [NMAP-1:0] ent_hi;
   genvar g;
   generate
      for (g = 0; g < NMAP; g++) begin : g_map
         wire [16:0] base = {1'b0, map_start_i[g*16 +: 16]} - 17'h00001;
         wire [16:0] off = cur_ref - base;
         wire [17:0] span = {1'b0, map_qty_i[g*16 +: 16], 1'b0};
         assign hit[g] = map_start_i[g*16 +: 16] != 16'h0000 && cur_ref >= base
            && {1'b0, off} < span;
         assign ent_pt[g] = {1'b0, map_start_i[g*16 +: 16]} + {1'b0, off[16:1]};
         assign ent_hi[g] = off[0];
      end
   endgenerate

   logic map_hit;
   logic [16:0] map_pt;
   logic map_hi;
   always_comb begin
      map_hit = 1'b0;
      map_pt = 17'h00000;
      map_hi = 1'b0;
      for (int i = NMAP - 1; i >= 0; i--) begin
         if (hit[i]) begin
            map_hit = 1'b1;
            map_pt = ent_pt[i];
            map_hi = ent_hi[i];
         end
      end
   end

   // ==========================================
   // Per-step decode
   wire is_bin = func == mrp_pkg::FC_RD_COILS || func == mrp_pkg::FC_RD_DISC;
   wire is_wr = func == mrp_pkg::FC_WR_ONE || func == mrp_pkg::FC_WR_MULTI;
   wire walking = st == ST_WALK;
   wire [16:0] tgt_pt = (map_hit && !is_bin) ? map_pt : cur_ref + 17'h00001;
   wire addr_bad = tgt_pt >= mrp_pkg::POINT_LIMIT;
   wire type32 = pt_type_i == mrp_pkg::PT_AI32 || pt_type_i == mrp_pkg::PT_CTR32
      || pt_type_i == mrp_pkg::PT_FLOAT;
   wire is32 = !is_bin && (map_hit || (pt_exists_i && type32));
   wire [15:0] need = is32 ? mrp_pkg::TWO_REG : mrp_pkg::ONE_REG;
   wire short_fit = need > remain;
   wire hi_start = first && map_hit && map_hi && !is_bin;
   wire last_step = remain == need;
   wire wr_bad = !pt_exists_i || !pt_wr_ok_i;
   wire any_next = any_ok || pt_exists_i;
   wire [7:0] end_exc = (!is_wr && !any_next) ? mrp_pkg::EXC_ILL_FUNC : mrp_pkg::EXC_NONE;
   wire step_err = addr_bad || hi_start || (is_wr && !short_fit && wr_bad);
   wire [7:0] err_exc = (addr_bad || hi_start) ? mrp_pkg::EXC_ILL_ADDR : mrp_pkg::EXC_ILL_FUNC;
   wire step_end = step_err || short_fit || last_step;
   wire sign16 = pt_type_i == mrp_pkg::PT_AI16;
   wire [31:0] wdata16 = {{16{sign16 & req_word_i[15]}}, req_word_i};
   wire [7:0] bit_sh_next = bit_sh | (8'h01 << bit_cnt);
   wire bit_val = pt_exists_i && pt_rdata_i[0];
   wire [15:0] rd_low = pt_exists_i ? pt_rdata_i[15:0] : 16'h0000;

   assign req_ready_o = st == ST_IDLE;
   assign req_word_idx_o = widx;
   assign pt_num_o = tgt_pt[15:0];
   assign pt_wr_o = walking && is_wr && !addr_bad && !hi_start && !short_fit && pt_exists_i;
   assign pt_wdata_o = is32 ? {req_word_next_i, req_word_i} : wdata16;
   assign rsp_valid_o = out_valid;
   assign rsp_data_o = out_word;
   assign rsp_done_o = st == ST_DONE;
   assign rsp_exc_o = exc;

   // ==========================================
   // Sequencer, ascending one point per step
   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         st <= ST_IDLE;
         func <= 8'h00;
         cur_ref <= 17'h00000;
         remain <= 16'h0000;
         widx <= '0;
         any_ok <= 1'b0;
         first <= 1'b0;
         exc <= mrp_pkg::EXC_NONE;
         hi_word <= 16'h0000;
         bit_sh <= 8'h00;
         bit_cnt <= 3'h0;
         out_word <= 16'h0000;
         out_valid <= 1'b0;
      end else begin
         out_valid <= 1'b0;
         case (st)
            ST_IDLE: begin
               if (accept) begin
                  func <= req_func_i;
                  cur_ref <= {1'b0, req_start_i};
                  remain <= in_count;
                  widx <= '0;
                  any_ok <= 1'b0;
                  first <= 1'b1;
                  bit_sh <= 8'h00;
                  bit_cnt <= 3'h0;
                  exc <= pre_exc;
                  if (pre_exc != mrp_pkg::EXC_NONE) begin
                     st <= ST_DONE;
                  end else if (gw_mode_i) begin
                     st <= ST_GW;
                  end else begin
                     st <= ST_WALK;
                  end
               end
            end
            ST_GW: begin
               if (gw_timeout_i) begin
                  exc <= mrp_pkg::EXC_GW_NO_RSP;
                  st <= ST_DONE;
               end else if (gw_reply_i) begin
                  st <= ST_DONE;
               end
            end
            ST_WALK: begin
               first <= 1'b0;
               if (!step_err && !short_fit) begin
                  any_ok <= any_next;
                  cur_ref <= cur_ref + {1'b0, need};
                  remain <= remain - need;
                  widx <= widx + need[AW-1:0];
                  if (is_bin) begin
                     bit_sh <= bit_val ? bit_sh_next : bit_sh;
                     bit_cnt <= bit_cnt + 3'h1;
                     if (bit_cnt == mrp_pkg::BIT_LAST || last_step) begin
                        out_valid <= 1'b1;
                        out_word <= {8'h00, bit_val ? bit_sh_next : bit_sh};
                        bit_sh <= 8'h00;
                        bit_cnt <= 3'h0;
                     end
                  end else if (!is_wr) begin
                     out_valid <= 1'b1;
                     out_word <= rd_low;
                     hi_word <= pt_exists_i ? pt_rdata_i[31:16] : 16'h0000;
                  end
               end
               if (step_err) begin
                  exc <= err_exc;
                  st <= ST_DONE;
               end else if (!short_fit && is32 && !is_wr) begin
                  st <= ST_HIGH;
               end else if (step_end) begin
                  exc <= short_fit ? ((!is_wr && !any_ok) ? mrp_pkg::EXC_ILL_FUNC
                     : mrp_pkg::EXC_NONE) : end_exc;
                  st <= ST_DONE;
               end
            end
            ST_HIGH: begin
               out_valid <= 1'b1;
               out_word <= hi_word;
               if (remain == 16'h0000) begin
                  exc <= any_ok ? mrp_pkg::EXC_NONE : mrp_pkg::EXC_ILL_FUNC;
                  st <= ST_DONE;
               end else begin
                  st <= ST_WALK;
               end
            end
            ST_DONE: begin
               st <= ST_IDLE;
            end
            default: begin
               st <= ST_IDLE;
            end
         endcase
      end
   end

   // ==========================================
   // Checks
   a_linear_map: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      walking && !map_hit && !is_bin |-> pt_num_o == cur_ref[15:0] + 16'h0001)
      else $error("linear point mapping wrong");
   a_pair_example: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      walking && !is_bin && map_start_i[15:0] == 16'h03e9 && map_qty_i[15:0] >= 16'h0004
      && cur_ref == 17'h003ec |-> pt_num_o == 16'h03eb)
      else $error("pair did not resolve to point 1003");
   a_high_reject: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      walking && hi_start |-> !pt_wr_o ##1 rsp_done_o && rsp_exc_o == 8'h02)
      else $error("high word start not rejected");
   a_write_fail: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      pt_wr_o && !pt_wr_ok_i |=> rsp_done_o && rsp_exc_o == 8'h01)
      else $error("failed control did not stop the write");
   a_write_16: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      pt_wr_o && !is32 |-> pt_wdata_o[15:0] == req_word_i
      && (first || widx == $past(widx) + $past(need[AW-1:0])))
      else $error("16-bit write value wrong");
   a_write_32: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      pt_wr_o && is32 |-> pt_wdata_o == {req_word_next_i, req_word_i})
      else $error("32-bit write word order wrong");
   a_read_32: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      walking && !is_wr && is32 && !short_fit && !step_err && pt_exists_i
      |=> rsp_valid_o && rsp_data_o == $past(pt_rdata_i[15:0])
      ##1 rsp_valid_o && rsp_data_o == $past(pt_rdata_i[31:16], 2))
      else $error("32-bit read word order wrong");
   a_len_limit: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      accept && in_rd_reg && in_count > 16'h007f |=> rsp_done_o && rsp_exc_o == 8'h04)
      else $error("long response not refused");
   a_bad_func: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      accept && !(in_bin || in_reg || in_one) |=> rsp_done_o && rsp_exc_o == 8'h01)
      else $error("unsupported function not refused");
   a_gw_timeout: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      st == ST_GW && gw_timeout_i |=> rsp_done_o && rsp_exc_o == 8'h0a)
      else $error("gateway timeout code wrong");
   a_short_stop: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      walking && short_fit |-> !pt_wr_o ##1 rsp_done_o)
      else $error("overrunning point was handled");
   c_write_multi: cover property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      pt_wr_o && is32 ##1 pt_wr_o);
   c_read_mapped: cover property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      walking && map_hit && !is_wr ##2 rsp_done_o && rsp_exc_o == 8'h00);
   c_bin_byte: cover property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      walking && is_bin && bit_cnt == 3'h7);
endmodule

// ==== testbench/mrp_point_db.sv ====
// Point database model answering the mapper's point accesses
`timescale 1ns/1ps
module mrp_point_db (
   input wire logic clk_sys_i,
   input wire logic [15:0] pt_num_i,
   input wire logic pt_wr_i,
   input wire logic [31:0] pt_wdata_i,
   output logic pt_exists_o,
   output logic [2:0] pt_type_o,
   output logic [31:0] pt_rdata_o,
   output logic pt_wr_ok_o
);
   logic [15:0] wnum[$];
   logic [31:0] wdat[$];
   // ==========================================
   // Points 1001 to 1009 exist; the control of 1009 always fails
   assign pt_exists_o = (pt_num_i >= 16'h03e9) && (pt_num_i <= 16'h03f1);
   assign pt_wr_ok_o = (pt_num_i != 16'h03f1);
   assign pt_rdata_o = {pt_num_i ^ 16'ha5a5, pt_num_i};
   assign pt_type_o = (pt_num_i == 16'h03eb) ? 3'h2 :
                      (pt_num_i == 16'h03ea) ? 3'h3 :
                      (pt_num_i == 16'h03ec) ? 3'h4 :
                      (pt_num_i == 16'h03ed) ? 3'h5 : 3'h1;
   // ==========================================
   // Write log, including strobes whose control fails
   always @(posedge clk_sys_i) begin
      if (pt_wr_i === 1'b1) begin
         wnum.push_back(pt_num_i);
         wdat.push_back(pt_wdata_i);
      end
   end
endmodule

// ==== testbench/modbus_register_point_mapper_tb.sv ====
// Self-checking bench for the register-to-point mapper
`timescale 1ns/1ps
module modbus_register_point_mapper_tb;
   logic clk_sys_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic req_valid = 1'b0;
   logic [7:0] req_func = 8'h00;
   logic [15:0] req_start = 16'h0000;
   logic [15:0] req_count = 16'h0000;
   logic gw_mode = 1'b0;
   logic gw_reply = 1'b0;
   logic gw_timeout = 1'b0;
   logic [63:0] map_start = {48'h0, 16'h03ec};
   logic [63:0] map_qty = {48'h0, 16'h0002};
   logic [15:0] wd[0:15];
   logic req_ready_o, pt_wr_o, pt_exists, pt_wr_ok, rsp_valid_o, rsp_done_o;
   logic [7:0] req_word_idx_o, rsp_exc_o, exc_seen;
   logic [15:0] pt_num_o, rsp_data_o;
   logic [2:0] pt_type;
   logic [31:0] pt_rdata, pt_wdata_o;
   logic [15:0] rq[$];
   logic [15:0] r0, r1, r2;
   int failures = 0;
   int checked = 0;

   initial forever #50 clk_sys_i = ~clk_sys_i;

   mrp_point_mapper #(.NMAP(4), .AW(8)) mrp_point_mapper_i (
      .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
      .map_start_i(map_start), .map_qty_i(map_qty),
      .req_valid_i(req_valid), .req_ready_o(req_ready_o), .req_func_i(req_func),
      .req_start_i(req_start), .req_count_i(req_count), .gw_mode_i(gw_mode),
      .gw_reply_i(gw_reply), .gw_timeout_i(gw_timeout), .req_word_idx_o(req_word_idx_o),
      .req_word_i(wd[req_word_idx_o[3:0]]), .req_word_next_i(wd[req_word_idx_o[3:0] + 4'h1]),
      .pt_num_o(pt_num_o), .pt_exists_i(pt_exists), .pt_type_i(pt_type), .pt_rdata_i(pt_rdata),
      .pt_wr_o(pt_wr_o), .pt_wdata_o(pt_wdata_o), .pt_wr_ok_i(pt_wr_ok),
      .rsp_valid_o(rsp_valid_o), .rsp_data_o(rsp_data_o), .rsp_done_o(rsp_done_o), .rsp_exc_o(rsp_exc_o)
   );

   mrp_point_db mrp_point_db_i (
      .clk_sys_i(clk_sys_i), .pt_num_i(pt_num_o), .pt_wr_i(pt_wr_o), .pt_wdata_i(pt_wdata_o),
      .pt_exists_o(pt_exists), .pt_type_o(pt_type), .pt_rdata_o(pt_rdata), .pt_wr_ok_o(pt_wr_ok)
   );

   function automatic logic [31:0] pv(input logic [15:0] n);
      return {n ^ 16'ha5a5, n};
   endfunction

   function automatic logic [31:0] sx(input logic [15:0] w);
      return {{16{w[15]}}, w};
   endfunction

   task automatic final_report();
      $display("checked %0d failures %0d", checked, failures);
      if (failures == 0 && checked > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checked++;
      if (g !== e) begin
         failures++;
         $display("FAIL %s expected %h seen %h", nm, e, g);
      end
   endtask

   // One request: present, wait for acceptance, collect words until done
   task automatic run_req(input logic [7:0] f, input logic [15:0] s, input logic [15:0] c);
      int n;
      rq.delete();
      mrp_point_db_i.wnum.delete();
      mrp_point_db_i.wdat.delete();
      exc_seen = 8'hff;
      @(posedge clk_sys_i);
      req_func <= f;
      req_start <= s;
      req_count <= c;
      req_valid <= 1'b1;
      n = 0;
      @(negedge clk_sys_i);
      while (req_ready_o !== 1'b1 && n < 50) begin
         n++;
         @(negedge clk_sys_i);
      end
      @(posedge clk_sys_i);
      req_valid <= 1'b0;
      for (n = 0; n < 600; n++) begin
         @(negedge clk_sys_i);
         if (rsp_valid_o === 1'b1) rq.push_back(rsp_data_o);
         if (rsp_done_o === 1'b1) begin
            exc_seen = rsp_exc_o;
            break;
         end
      end
      @(posedge clk_sys_i);
   endtask

   task automatic chk_wr(input int i, input logic [15:0] num, input logic [31:0] dat);
      chk("write point", {16'h0, num}, {16'h0, mrp_point_db_i.wnum[i]});
      chk("write value", dat, mrp_point_db_i.wdat[i]);
   endtask

   task automatic exc_case(input logic [7:0] f, input logic [15:0] s, input logic [15:0] c,
                           input logic gm, input logic rp, input logic to, input logic [7:0] e);
      gw_mode <= gm;
      gw_reply <= rp;
      gw_timeout <= to;
      run_req(f, s, c);
      chk("exception", {24'h0, e}, {24'h0, exc_seen});
      gw_mode <= 1'b0;
      gw_reply <= 1'b0;
      gw_timeout <= 1'b0;
   endtask

   initial begin
      repeat (20000) @(posedge clk_sys_i);
      failures++;
      final_report();
   end

   initial begin
      for (int i = 0; i < 16; i++) wd[i] <= 16'h0000;
      repeat (12) @(posedge clk_sys_i);
      rst_n_i <= 1'b1;
      void'($urandom(90542));
      // ==========================================
      // Multi-write from 1000 over a 16-bit and a 32-bit point
      r0 = 16'h8000 | 16'($urandom());
      r1 = 16'($urandom());
      r2 = 16'($urandom());
      wd[0] <= r0;
      wd[1] <= r1;
      wd[2] <= r2;
      run_req(8'h10, 16'h03e8, 16'h0003);
      chk("write count", 32'h2, mrp_point_db_i.wnum.size());
      chk_wr(0, 16'h03e9, sx(r0));
      chk_wr(1, 16'h03ea, {r2, r1});
      chk("exception", 32'h0, {24'h0, exc_seen});
      run_req(8'h10, 16'h03e8, 16'h0002);
      chk("write count", 32'h1, mrp_point_db_i.wnum.size());
      chk("exception", 32'h0, {24'h0, exc_seen});
      // ==========================================
      // Reads in mixed widths and data types
      run_req(8'h03, 16'h03e8, 16'h0003);
      chk("read count", 32'h3, rq.size());
      chk("rsp", pv(16'h03e9) & 32'h0000ffff, {16'h0, rq[0]});
      chk("rsp", pv(16'h03ea), {rq[2], rq[1]});
      run_req(8'h04, 16'h03eb, 16'h0004);
      chk("rsp", pv(16'h03ec), {rq[1], rq[0]});
      chk("rsp", pv(16'h03ed), {rq[3], rq[2]});
      // ==========================================
      // Fixed pair mapping and high-word refusals
      wd[0] <= r2;
      wd[1] <= r0;
      run_req(8'h10, 16'h03ed, 16'h0002);
      chk("write count", 32'h1, mrp_point_db_i.wnum.size());
      chk_wr(0, 16'h03ed, {r0, r2});
      exc_case(8'h06, 16'h03ec, 16'h0001, 1'b0, 1'b0, 1'b0, 8'h02);
      chk("write count", 32'h0, mrp_point_db_i.wnum.size());
      exc_case(8'h03, 16'h03ec, 16'h0002, 1'b0, 1'b0, 1'b0, 8'h02);
      // ==========================================
      // Failed control stops the walk
      exc_case(8'h10, 16'h03ef, 16'h0003, 1'b0, 1'b0, 1'b0, 8'h01);
      chk("write count", 32'h2, mrp_point_db_i.wnum.size());
      chk_wr(1, 16'h03f1, sx(r0));
      // ==========================================
      // Table entry at 1001 over four points
      map_start <= {48'h0, 16'h03e9};
      map_qty <= {48'h0, 16'h0004};
      wd[0] <= r1;
      wd[1] <= r2;
      run_req(8'h10, 16'h03ec, 16'h0002);
      chk("write count", 32'h1, mrp_point_db_i.wnum.size());
      chk_wr(0, 16'h03eb, {r2, r1});
      exc_case(8'h06, 16'h03ed, 16'h0001, 1'b0, 1'b0, 1'b0, 8'h02);
      map_start <= {48'h0, 16'h03ec};
      map_qty <= {48'h0, 16'h0002};
      // ==========================================
      // Partly missing reads and bit packing
      run_req(8'h03, 16'h03f0, 16'h0003);
      chk("rsp", pv(16'h03f1) << 16, {rq[0], rq[2]});
      chk("exception", 32'h0, {24'h0, exc_seen});
      exc_case(8'h03, 16'h0bb8, 16'h0002, 1'b0, 1'b0, 1'b0, 8'h01);
      run_req(8'h02, 16'h03e8, 16'h000a);
      chk("bits", 32'h0155, {rq[1][7:0], rq[0][7:0]});
      // ==========================================
      // Exception codes
      exc_case(8'h07, 16'h03e8, 16'h0001, 1'b0, 1'b0, 1'b0, 8'h01);
      exc_case(8'h03, 16'h03e8, 16'h0000, 1'b0, 1'b0, 1'b0, 8'h03);
      exc_case(8'h03, 16'hffff, 16'h0001, 1'b0, 1'b0, 1'b0, 8'h02);
      exc_case(8'h03, 16'h03e8, 16'h007f, 1'b0, 1'b0, 1'b0, 8'h00);
      exc_case(8'h03, 16'h03e8, 16'h0080, 1'b0, 1'b0, 1'b0, 8'h04);
      exc_case(8'h06, 16'h0bb8, 16'h0001, 1'b0, 1'b0, 1'b0, 8'h01);
      exc_case(8'h03, 16'h03e8, 16'h0001, 1'b1, 1'b0, 1'b1, 8'h0a);
      exc_case(8'h03, 16'h03e8, 16'h0001, 1'b1, 1'b1, 1'b1, 8'h0a);
      exc_case(8'h03, 16'h03e8, 16'h0001, 1'b1, 1'b1, 1'b0, 8'h00);
      // ==========================================
      // Random single writes to a 16-bit point
      for (int k = 0; k < 10; k++) begin
         wd[0] <= 16'($urandom());
         run_req(8'h06, 16'h03ef, 16'h0001);
         chk_wr(0, 16'h03f0, sx(wd[0]));
      end
      // 16-bit counter point is zero-extended
      wd[0] <= 16'h8000 | 16'($urandom());
      run_req(8'h06, 16'h03ea, 16'h0001);
      chk_wr(0, 16'h03eb, {16'h0, wd[0]});
      final_report();
   end
endmodule
